/* File: verilog/csa_pkg.sv */
// Summary of operation
// R01: Without a command to send, the transmitter sends the guard tone.
// R02: No received guard or command tone raises receive alarm, blocks relays.
// R03: Receive alarm stays latched; only a received guard tone clears it.
// R04: Receive or transmit level below its limit activates the level alarm.
// R05: Watchdog timeout on the processor blocks transmitter and relay outputs.
// R06: Every restart enters a self-test phase before normal operation.
// R07: Self-test checks memory, settings, processor link, command port, lines.
// R08: Self-test fault isolates command module I/O and raises its alarms.
// R09: A switched relay supply lets the relays be disabled by removing it.
// R10: Loss of any monitored supply voltage asserts module reset and an alarm.
// R11: Lasting interference above a fixed threshold raises its alarm.
// R12: Switching mode evaluates interference only while one tone is sent.
// R13: Outgoing commands are handed to the processor with an interrupt.
// R14: On a processor interrupt the controller collects incoming commands.
// R15: Command data passes input buffer, register, and output buffer.
// R16: Any detected error sends an alarm message to the alarm output module.
// R17: The controller accesses processor memory and raises several interrupts.
// R18: Relay blocking ORs all fault sources and overrides any command output; level and noise alarms do not block.
package csa_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int WD_TIMEOUT_US = 10_000;
	localparam int WD_CYCLES = WD_TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam int NOISE_HOLD_MS = 100;
	localparam int NOISE_CYCLES = NOISE_HOLD_MS * (CLK_HZ / 1_000);
	localparam int TEST_LIMIT_MS = 50;
	localparam int TEST_CYCLES = TEST_LIMIT_MS * (CLK_HZ / 1_000);
	localparam int SUPPLY_RST_US = 100;
	localparam int SUPPLY_RST_CYCLES = SUPPLY_RST_US * (CLK_HZ / 1_000_000);

	// ****************************************************************
	// Widths and fixed values
	// ****************************************************************
	localparam int CMD_W = 4;
	localparam int LEVEL_W = 8;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 12;
	localparam int IRQ_W = 4;
	localparam int SUPPLY_W = 4;
	localparam int CNT_W = 32;
	localparam logic [7:0] NOISE_THRESHOLD = 8'h40;
	localparam int IRQ_CMD = 0;

	// Self-test check vector positions.
	localparam int CHK_MEM = 0;
	localparam int CHK_CONFIG = 1;
	localparam int CHK_DSP_LINK = 2;
	localparam int CHK_CMD_PORT = 3;
	localparam int CHK_LINE = 4;
	localparam int CHK_W = 5;

	// Alarm vector positions.
	localparam int ALM_RX = 0;
	localparam int ALM_LEVEL = 1;
	localparam int ALM_NOISE = 2;
	localparam int ALM_WD = 3;
	localparam int ALM_TEST = 4;
	localparam int ALM_SUPPLY = 5;
	localparam int ALM_W = 6;

	typedef enum logic [1:0] {
		CSA_ST_TEST,
		CSA_ST_RUN,
		CSA_ST_FAULT
	} csa_state_t;

endpackage : csa_pkg

/* File: verilog/csa_top.sv */
`timescale 1ns/1ps
`default_nettype none

module csa_top #(
	parameter int WD_CYCLES = csa_pkg::WD_CYCLES,
	parameter int NOISE_CYCLES = csa_pkg::NOISE_CYCLES,
	parameter int TEST_CYCLES = csa_pkg::TEST_CYCLES
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// Command module side.
	input wire logic [csa_pkg::CMD_W-1:0] CMD_IN_I,
	output logic [csa_pkg::CMD_W-1:0] CMD_OUT_O,
	output logic RELAY_SUPPLY_EN_O,
	output logic IFC_ISOLATE_O,
	// Signal processor command path.
	output logic [csa_pkg::CMD_W-1:0] DSP_TX_CMD_O,
	output logic [csa_pkg::IRQ_W-1:0] DSP_IRQ_O,
	input wire logic [csa_pkg::IRQ_W-1:1] SW_IRQ_I,
	input wire logic DSP_RX_IRQ_I,
	input wire logic [csa_pkg::CMD_W-1:0] DSP_RX_CMD_I,
	input wire logic DSP_ALIVE_I,
	// Signal processor memory access.
	input wire logic MEM_REQ_I,
	input wire logic MEM_WR_I,
	input wire logic [csa_pkg::ADDR_W-1:0] MEM_ADDR_I,
	input wire logic [csa_pkg::DATA_W-1:0] MEM_WDATA_I,
	output logic [csa_pkg::DATA_W-1:0] MEM_RDATA_O,
	output logic MEM_DONE_O,
	output logic MEM_BUSY_O,
	output logic DSP_RD_O,
	output logic DSP_WR_O,
	output logic [csa_pkg::ADDR_W-1:0] DSP_ADDR_O,
	output logic [csa_pkg::DATA_W-1:0] DSP_WDATA_O,
	input wire logic [csa_pkg::DATA_W-1:0] DSP_RDATA_I,
	input wire logic DSP_ACK_I,
	// Tone status and transmitter.
	input wire logic RX_GUARD_I,
	input wire logic RX_CMD_TONE_I,
	output logic TX_ENABLE_O,
	output logic TX_GUARD_O,
	output logic TX_CMD_TONE_O,
	// Level and interference supervision.
	input wire logic [csa_pkg::LEVEL_W-1:0] RX_LEVEL_I,
	input wire logic [csa_pkg::LEVEL_W-1:0] TX_LEVEL_I,
	input wire logic [csa_pkg::LEVEL_W-1:0] RX_LIMIT_I,
	input wire logic [csa_pkg::LEVEL_W-1:0] TX_LIMIT_I,
	input wire logic [csa_pkg::LEVEL_W-1:0] NOISE_LEVEL_I,
	input wire logic SWITCH_MODE_I,
	// Self-test and supplies.
	input wire logic CHECK_DONE_I,
	input wire logic [csa_pkg::CHK_W-1:0] CHECK_OK_I,
	input wire logic [csa_pkg::SUPPLY_W-1:0] SUPPLY_OK_I,
	output logic MODULE_RESET_O,
	output logic SELFTEST_ACTIVE_O,
	// Alarms.
	output logic [csa_pkg::ALM_W-1:0] ALARM_LED_O,
	output logic ALARM_RELAY_O,
	output logic [csa_pkg::ALM_W-1:0] ALARM_MSG_O,
	output logic ALARM_MSG_VALID_O
);

	// ****************************************************************
	// Helpers
	// ****************************************************************

	// Saturating increment shared by the watchdog, noise and self-test timers.
	function automatic logic [csa_pkg::CNT_W-1:0] csa_sat_inc(
		input logic [csa_pkg::CNT_W-1:0] cnt,
		input logic [csa_pkg::CNT_W-1:0] lim
	);
		csa_sat_inc = (cnt >= lim) ? lim : cnt + 32'h0000_0001;
	endfunction : csa_sat_inc

	localparam logic [csa_pkg::CNT_W-1:0] WD_LIM = 32'(WD_CYCLES - 1);
	localparam logic [csa_pkg::CNT_W-1:0] NOISE_LIM = 32'(NOISE_CYCLES - 1);
	localparam logic [csa_pkg::CNT_W-1:0] TEST_LIM = 32'(TEST_CYCLES - 1);
	localparam logic [11:0] SUP_RST =
		12'(csa_pkg::SUPPLY_RST_CYCLES);

	csa_pkg::csa_state_t state_reg;
	logic [csa_pkg::CNT_W-1:0] test_cnt_reg;
	logic [csa_pkg::CNT_W-1:0] wd_cnt_reg;
	logic [csa_pkg::CNT_W-1:0] noise_cnt_reg;
	logic [11:0] sup_cnt_reg;
	logic wd_fail_reg;
	logic rx_alarm_reg;
	logic level_alarm_reg;
	logic noise_alarm_reg;
	logic supply_alarm_reg;
	logic [csa_pkg::CMD_W-1:0] cmd_in_reg;
	logic [csa_pkg::CMD_W-1:0] rx_cmd_reg;
	logic [csa_pkg::ALM_W-1:0] alarm_prev_reg;
	logic [csa_pkg::ALM_W-1:0] alarm_vec;
	logic [csa_pkg::ALM_W-1:0] alarm_new;
	logic running;
	logic supply_loss;
	logic relay_block;
	logic noise_eval;

	// ****************************************************************
	// Self-test sequencing
	// ****************************************************************

	// Restart always lands in the test phase; a fault is held until restart
	// so a flaky module cannot drift back into service unobserved.
	always_ff @(posedge SYS_CLK_I) begin // see R06
		if (RST_I) begin
			state_reg <= csa_pkg::CSA_ST_TEST;
			test_cnt_reg <= '0;
		end else begin
			test_cnt_reg <= csa_sat_inc(test_cnt_reg, TEST_LIM);
			case (state_reg)
				csa_pkg::CSA_ST_TEST: begin
					if (CHECK_DONE_I) begin
						// All five check groups must pass.
						state_reg <= (&CHECK_OK_I) ? csa_pkg::CSA_ST_RUN :
							csa_pkg::CSA_ST_FAULT; // see R07
					end else if (test_cnt_reg == TEST_LIM) begin
						state_reg <= csa_pkg::CSA_ST_FAULT;
					end
				end
				csa_pkg::CSA_ST_RUN: state_reg <= csa_pkg::CSA_ST_RUN;
				csa_pkg::CSA_ST_FAULT: state_reg <= csa_pkg::CSA_ST_FAULT;
				default: state_reg <= csa_pkg::CSA_ST_FAULT;
			endcase
		end
	end

	assign running = (state_reg == csa_pkg::CSA_ST_RUN);
	assign SELFTEST_ACTIVE_O = (state_reg == csa_pkg::CSA_ST_TEST);

	// ****************************************************************
	// Supervision
	// ****************************************************************

	// Watchdog: any missing processor heartbeat for the full window fails.
	always_ff @(posedge SYS_CLK_I) begin // see R05
		if (RST_I) begin
			wd_cnt_reg <= '0;
			wd_fail_reg <= 1'b0;
		end else begin
			wd_cnt_reg <= DSP_ALIVE_I ? '0 : csa_sat_inc(wd_cnt_reg, WD_LIM);
			if (!DSP_ALIVE_I && wd_cnt_reg == WD_LIM) begin
				wd_fail_reg <= 1'b1;
			end
		end
	end

	// Receive alarm latches on loss of both tones; only guard clears it.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			rx_alarm_reg <= 1'b0;
		end else if (!RX_GUARD_I && !RX_CMD_TONE_I) begin
			rx_alarm_reg <= 1'b1; // see R02
		end else if (RX_GUARD_I) begin
			rx_alarm_reg <= 1'b0; // see R03
		end
	end

	// Levels follow the measurement; limits come from configuration.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			level_alarm_reg <= 1'b0;
		end else begin
			level_alarm_reg <= (RX_LEVEL_I < RX_LIMIT_I) ||
				(TX_LEVEL_I < TX_LIMIT_I); // see R04
		end
	end

	// Two simultaneous tones would swamp the measurement, so switching mode
	// evaluates only while a single tone is on the line.
	assign noise_eval = !SWITCH_MODE_I ||
		(TX_GUARD_O ^ TX_CMD_TONE_O); // see R12

	// A threshold crossing must persist for the whole window to count.
	always_ff @(posedge SYS_CLK_I) begin // see R11
		if (RST_I) begin
			noise_cnt_reg <= '0;
			noise_alarm_reg <= 1'b0;
		end else begin
			if (noise_eval && NOISE_LEVEL_I > csa_pkg::NOISE_THRESHOLD) begin
				noise_cnt_reg <= csa_sat_inc(noise_cnt_reg, NOISE_LIM);
			end else begin
				noise_cnt_reg <= '0;
			end
			noise_alarm_reg <= noise_eval && (noise_cnt_reg == NOISE_LIM);
		end
	end

	// Supply loss: stretched module reset and an alarm held until restart.
	assign supply_loss = !(&SUPPLY_OK_I);
	always_ff @(posedge SYS_CLK_I) begin // see R10
		if (RST_I) begin
			sup_cnt_reg <= '0;
			supply_alarm_reg <= 1'b0;
		end else if (supply_loss) begin
			sup_cnt_reg <= SUP_RST;
			supply_alarm_reg <= 1'b1;
		end else if (sup_cnt_reg != 12'h000) begin
			sup_cnt_reg <= sup_cnt_reg - 12'h001;
		end
	end
	assign MODULE_RESET_O = (sup_cnt_reg != 12'h000);

	// ****************************************************************
	// Command paths
	// ****************************************************************

	// A receive, watchdog, supply or self-test fault, or not yet in service, silences the relays.
	assign relay_block = rx_alarm_reg || wd_fail_reg || supply_alarm_reg ||
		(state_reg == csa_pkg::CSA_ST_FAULT) || !running; // see R18

	// Input buffer register; cleared while isolated or testing.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || !running) begin
			cmd_in_reg <= '0; // see R08
		end else begin
			cmd_in_reg <= CMD_IN_I; // see R15
		end
	end

	// Outgoing commands: a change is handed over with the command interrupt.
	// Other interrupt lines forward controller-side triggers one for one.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			DSP_TX_CMD_O <= '0;
			DSP_IRQ_O <= '0;
		end else begin
			DSP_IRQ_O[csa_pkg::IRQ_W-1:1] <= SW_IRQ_I; // see R17
			DSP_IRQ_O[csa_pkg::IRQ_CMD] <= (cmd_in_reg != DSP_TX_CMD_O);
			if (cmd_in_reg != DSP_TX_CMD_O) begin
				DSP_TX_CMD_O <= cmd_in_reg; // see R13
			end
		end
	end

	// Incoming commands are collected on the processor interrupt.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || !running) begin
			rx_cmd_reg <= '0;
		end else if (DSP_RX_IRQ_I) begin
			rx_cmd_reg <= DSP_RX_CMD_I; // see R14
		end
	end

	// Output buffer and switched relay supply, both gated by the block.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			CMD_OUT_O <= '0;
			RELAY_SUPPLY_EN_O <= 1'b0;
			IFC_ISOLATE_O <= 1'b1;
		end else begin
			CMD_OUT_O <= relay_block ? '0 : rx_cmd_reg; // see R15
			RELAY_SUPPLY_EN_O <= !relay_block; // see R09
			IFC_ISOLATE_O <= (state_reg == csa_pkg::CSA_ST_FAULT); // see R08
		end
	end

	// Transmitter: guard whenever enabled and no command is pending.
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			TX_ENABLE_O <= 1'b0;
			TX_GUARD_O <= 1'b0;
			TX_CMD_TONE_O <= 1'b0;
		end else begin
			TX_ENABLE_O <= !wd_fail_reg &&
				(state_reg != csa_pkg::CSA_ST_FAULT); // see R05
			TX_GUARD_O <= TX_ENABLE_O && (DSP_TX_CMD_O == '0); // see R01
			TX_CMD_TONE_O <= TX_ENABLE_O && (DSP_TX_CMD_O != '0);
		end
	end

	// ****************************************************************
	// Processor memory access
	// ****************************************************************

	// One access at a time; strobes hold until the processor acknowledges.
	always_ff @(posedge SYS_CLK_I) begin // see R17
		if (RST_I) begin
			DSP_RD_O <= 1'b0;
			DSP_WR_O <= 1'b0;
			DSP_ADDR_O <= '0;
			DSP_WDATA_O <= '0;
			MEM_RDATA_O <= '0;
			MEM_DONE_O <= 1'b0;
		end else begin
			MEM_DONE_O <= 1'b0;
			if (MEM_BUSY_O) begin
				if (DSP_ACK_I) begin
					DSP_RD_O <= 1'b0;
					DSP_WR_O <= 1'b0;
					MEM_DONE_O <= 1'b1;
					if (DSP_RD_O) begin
						MEM_RDATA_O <= DSP_RDATA_I;
					end
				end
			end else if (MEM_REQ_I) begin
				DSP_RD_O <= !MEM_WR_I;
				DSP_WR_O <= MEM_WR_I;
				DSP_ADDR_O <= MEM_ADDR_I;
				DSP_WDATA_O <= MEM_WDATA_I;
			end
		end
	end
	assign MEM_BUSY_O = DSP_RD_O || DSP_WR_O;

	// ****************************************************************
	// Alarm reporting
	// ****************************************************************

	always_comb begin
		alarm_vec = '0;
		alarm_vec[csa_pkg::ALM_RX] = rx_alarm_reg;
		alarm_vec[csa_pkg::ALM_LEVEL] = level_alarm_reg;
		alarm_vec[csa_pkg::ALM_NOISE] = noise_alarm_reg;
		alarm_vec[csa_pkg::ALM_WD] = wd_fail_reg;
		alarm_vec[csa_pkg::ALM_TEST] = (state_reg == csa_pkg::CSA_ST_FAULT);
		alarm_vec[csa_pkg::ALM_SUPPLY] = supply_alarm_reg;
	end
	assign alarm_new = alarm_vec & ~alarm_prev_reg;

	// A message goes out on each newly raised alarm, carrying the full set.
	always_ff @(posedge SYS_CLK_I) begin // see R16
		if (RST_I) begin
			alarm_prev_reg <= '0;
			ALARM_LED_O <= '0;
			ALARM_RELAY_O <= 1'b0;
			ALARM_MSG_O <= '0;
			ALARM_MSG_VALID_O <= 1'b0;
		end else begin
			alarm_prev_reg <= alarm_vec;
			ALARM_LED_O <= alarm_vec;
			ALARM_RELAY_O <= |alarm_vec;
			ALARM_MSG_VALID_O <= |alarm_new;
			if (|alarm_new) begin
				ALARM_MSG_O <= alarm_vec;
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************

	default clocking csa_cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RST_I);

	sequence s_cmd_change;
		running && (cmd_in_reg != DSP_TX_CMD_O);
	endsequence
	sequence s_cmd_handover;
		DSP_IRQ_O[csa_pkg::IRQ_CMD] && (DSP_TX_CMD_O == $past(cmd_in_reg));
	endsequence
	sequence s_wd_expire;
		!DSP_ALIVE_I && (wd_cnt_reg == WD_LIM);
	endsequence

	a_guard_when_idle: assert property ( // see R01
		TX_ENABLE_O && DSP_TX_CMD_O == '0 |=> TX_GUARD_O && !TX_CMD_TONE_O)
		else $error("guard tone missing while idle");
	a_rx_alarm_set: assert property ( // see R02
		!RX_GUARD_I && !RX_CMD_TONE_I |=> rx_alarm_reg ##1 CMD_OUT_O == '0)
		else $error("tone loss did not alarm and block");
	a_rx_alarm_latch: assert property ( // see R03
		rx_alarm_reg && !RX_GUARD_I |=> rx_alarm_reg)
		else $error("receive alarm cleared without guard");
	a_level_alarm: assert property ( // see R04
		(RX_LEVEL_I < RX_LIMIT_I) || (TX_LEVEL_I < TX_LIMIT_I)
		|-> ##2 ALARM_LED_O[csa_pkg::ALM_LEVEL])
		else $error("low level not alarmed");
	a_wd_block: assert property ( // see R05
		s_wd_expire |=> wd_fail_reg ##1 (!TX_ENABLE_O && !RELAY_SUPPLY_EN_O))
		else $error("watchdog failure did not block outputs");
	a_test_after_reset: assert property ( // see R06
		$past(RST_I) |-> state_reg == csa_pkg::CSA_ST_TEST)
		else $error("restart skipped self-test");
	a_fault_isolate: assert property ( // see R08
		state_reg == csa_pkg::CSA_ST_FAULT |=> IFC_ISOLATE_O && CMD_OUT_O == '0
		&& ALARM_LED_O[csa_pkg::ALM_TEST])
		else $error("self-test fault did not isolate");
	a_supply_reset: assert property ( // see R10
		supply_loss |=> MODULE_RESET_O && supply_alarm_reg)
		else $error("supply loss did not reset");
	a_noise_gate: assert property ( // see R12
		SWITCH_MODE_I && !(TX_GUARD_O ^ TX_CMD_TONE_O) |=> noise_cnt_reg == '0)
		else $error("interference evaluated with two tones");
	a_cmd_irq: assert property ( // see R13
		s_cmd_change |=> s_cmd_handover)
		else $error("command change not handed over");
	a_alarm_msg: assert property ( // see R16
		|alarm_new |=> ALARM_MSG_VALID_O && ALARM_MSG_O == $past(alarm_vec))
		else $error("new alarm sent no message");
	a_mem_done: assert property ( // see R17
		MEM_BUSY_O && DSP_ACK_I |=> MEM_DONE_O && !MEM_BUSY_O ##1 !MEM_DONE_O)
		else $error("memory access not completed");
	a_relay_block: assert property ( // see R18
		relay_block |=> CMD_OUT_O == '0 && !RELAY_SUPPLY_EN_O)
		else $error("relays driven while blocked");

endmodule : csa_top

`default_nettype wire

/* File: dv/csa_dsp_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Signal processor stand-in
// ****************************************************************
module csa_dsp_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [11:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [3:0] irq_i,
	input wire logic [3:0] tx_cmd_i,
	input wire logic slow_i,
	input wire logic alive_en_i,
	input wire logic send_i,
	input wire logic [3:0] send_cmd_i,
	output logic [15:0] rdata_o,
	output logic ack_o,
	output logic alive_o,
	output logic rx_irq_o,
	output logic [3:0] rx_cmd_o,
	output logic [3:0] got_cmd_o,
	output int irq_cnt_o
);
	logic [15:0] mem [16];
	logic [3:0] wait_reg;
	logic [2:0] beat_reg;
	logic tog_reg;

	// Outside an answer the buses show a moving pattern, never stale data.
	assign rdata_o = ack_o ? mem[addr_i[3:0]] : {16{tog_reg}} ^ 16'hA5C3;
	assign rx_irq_o = send_i;
	assign rx_cmd_o = send_i ? send_cmd_i : {4{tog_reg}};
	assign alive_o = alive_en_i && beat_reg == 3'h0;

	// The slow answer keeps the strobe waiting five extra cycles.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			wait_reg <= 4'h0;
			beat_reg <= 3'h0;
			tog_reg <= 1'b0;
			irq_cnt_o <= 0;
			got_cmd_o <= 4'h0;
		end else begin
			tog_reg <= !tog_reg;
			beat_reg <= beat_reg + 3'h1;
			if (irq_i[0]) begin
				got_cmd_o <= tx_cmd_i;
				irq_cnt_o <= irq_cnt_o + 1;
			end
			if (ack_o || !(rd_i || wr_i)) begin
				ack_o <= 1'b0;
				wait_reg <= 4'h0;
			end else if (wait_reg >= (slow_i ? 4'h5 : 4'h0)) begin
				ack_o <= 1'b1;
				if (wr_i) mem[addr_i[3:0]] <= wdata_i;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule : csa_dsp_model

`default_nettype wire

/* File: dv/csa_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module csa_top_tb;
	localparam int WD = 20;
	localparam int NZ = 16;
	localparam int TST = 50;
	logic SYS_CLK_I = 1'b0, RST_I = 1'b1, MEM_REQ_I = 1'b0, MEM_WR_I = 1'b0;
	logic RX_GUARD_I = 1'b1, RX_CMD_TONE_I = 1'b0, SWITCH_MODE_I = 1'b1;
	logic CHECK_DONE_I = 1'b0, slow = 1'b0, alive_en = 1'b1, rx_go = 1'b0;
	logic [3:0] CMD_IN_I = 4'h0, SUPPLY_OK_I = 4'hF, rx_val = 4'h0;
	logic [3:1] SW_IRQ_I = 3'h0;
	logic [4:0] CHECK_OK_I = 5'h1F;
	logic [11:0] MEM_ADDR_I = 12'h000;
	logic [15:0] MEM_WDATA_I = 16'h0000;
	logic [7:0] RX_LEVEL_I = 8'h80, TX_LEVEL_I = 8'h80, NOISE_LEVEL_I = 8'h10;
	logic [7:0] RX_LIMIT_I = 8'h40, TX_LIMIT_I = 8'h40;
	logic DSP_RX_IRQ_I, DSP_ALIVE_I, DSP_ACK_I, MEM_DONE_O, MEM_BUSY_O;
	logic DSP_RD_O, DSP_WR_O, RELAY_SUPPLY_EN_O, IFC_ISOLATE_O, TX_ENABLE_O;
	logic TX_GUARD_O, TX_CMD_TONE_O, MODULE_RESET_O, SELFTEST_ACTIVE_O;
	logic ALARM_RELAY_O, ALARM_MSG_VALID_O;
	logic [3:0] DSP_RX_CMD_I, CMD_OUT_O, DSP_TX_CMD_O, DSP_IRQ_O, got_cmd;
	logic [11:0] DSP_ADDR_O;
	logic [15:0] DSP_RDATA_I, MEM_RDATA_O, DSP_WDATA_O;
	logic [5:0] ALARM_LED_O, ALARM_MSG_O;
	int fail_count = 0, checks_done = 0, msg_cnt = 0, cycles = 0, irq_cnt;

	// Short counts keep the watchdog, noise and test windows cheap.
	csa_top #(.WD_CYCLES(WD), .NOISE_CYCLES(NZ), .TEST_CYCLES(TST)) u_csa_top (
		.SYS_CLK_I, .RST_I, .CMD_IN_I, .CMD_OUT_O, .RELAY_SUPPLY_EN_O,
		.IFC_ISOLATE_O, .DSP_TX_CMD_O, .DSP_IRQ_O, .SW_IRQ_I, .DSP_RX_IRQ_I,
		.DSP_RX_CMD_I, .DSP_ALIVE_I, .MEM_REQ_I, .MEM_WR_I, .MEM_ADDR_I,
		.MEM_WDATA_I, .MEM_RDATA_O, .MEM_DONE_O, .MEM_BUSY_O, .DSP_RD_O,
		.DSP_WR_O, .DSP_ADDR_O, .DSP_WDATA_O, .DSP_RDATA_I, .DSP_ACK_I,
		.RX_GUARD_I, .RX_CMD_TONE_I, .TX_ENABLE_O, .TX_GUARD_O,
		.TX_CMD_TONE_O, .RX_LEVEL_I, .TX_LEVEL_I, .RX_LIMIT_I, .TX_LIMIT_I,
		.NOISE_LEVEL_I, .SWITCH_MODE_I, .CHECK_DONE_I, .CHECK_OK_I,
		.SUPPLY_OK_I, .MODULE_RESET_O, .SELFTEST_ACTIVE_O, .ALARM_LED_O,
		.ALARM_RELAY_O, .ALARM_MSG_O, .ALARM_MSG_VALID_O
	);

	// The processor model answers the memory port and the command interrupt.
	csa_dsp_model u_csa_dsp_model (
		.clk_i(SYS_CLK_I), .rst_i(RST_I), .rd_i(DSP_RD_O), .wr_i(DSP_WR_O),
		.addr_i(DSP_ADDR_O), .wdata_i(DSP_WDATA_O), .irq_i(DSP_IRQ_O),
		.tx_cmd_i(DSP_TX_CMD_O), .slow_i(slow), .alive_en_i(alive_en),
		.send_i(rx_go), .send_cmd_i(rx_val), .rdata_o(DSP_RDATA_I),
		.ack_o(DSP_ACK_I), .alive_o(DSP_ALIVE_I), .rx_irq_o(DSP_RX_IRQ_I),
		.rx_cmd_o(DSP_RX_CMD_I), .got_cmd_o(got_cmd), .irq_cnt_o(irq_cnt)
	);

	// ****************************************************************
	// Clock, watchdog on the run and shared tasks
	// ****************************************************************
	always #25 SYS_CLK_I = !SYS_CLK_I;

	// Pulses are counted at the falling edge, where they have settled.
	always @(negedge SYS_CLK_I) begin
		cycles++;
		if (ALARM_MSG_VALID_O === 1'b1) msg_cnt++;
		if (cycles == 10000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic chk1(input string n, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", n, e, g);
		end
	endtask : chk1

	task automatic chkv(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chkv

	task automatic cyc(input int n);
		repeat (n) @(negedge SYS_CLK_I);
	endtask : cyc

	// Restart, then give the test verdict or let the test time out.
	task automatic boot(input logic [4:0] ok, input logic pulse);
		RST_I = 1'b1;
		cyc(6);
		RST_I = 1'b0;
		chk1("isolate", 1'b1, IFC_ISOLATE_O);
		chk1("selftest", 1'b1, SELFTEST_ACTIVE_O);
		cyc(1);
		CHECK_OK_I = ok;
		CHECK_DONE_I = pulse;
		cyc(1);
		CHECK_DONE_I = 1'b0;
		cyc(pulse ? 6 : TST + 6);
		chk1("selftest", 1'b0, SELFTEST_ACTIVE_O);
	endtask : boot

	// An incoming command arrives with the processor interrupt.
	task automatic send(input logic [3:0] c);
		rx_val = c;
		rx_go = 1'b1;
		cyc(1);
		rx_go = 1'b0;
		cyc(3);
	endtask : send

	// The request is held for the one edge that takes it.
	task automatic mem(input logic w, input logic [11:0] a,
		input logic [15:0] d);
		MEM_REQ_I = 1'b1;
		MEM_WR_I = w;
		MEM_ADDR_I = a;
		MEM_WDATA_I = d;
		cyc(1);
		MEM_REQ_I = 1'b0;
		chk1("mem busy", 1'b1, MEM_BUSY_O);
		for (int i = 0; i < 20 && MEM_DONE_O !== 1'b1; i++) cyc(1);
		chk1("mem done", 1'b1, MEM_DONE_O);
	endtask : mem

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_out();
		int n;
		n = irq_cnt;
		CMD_IN_I = 4'h5;
		cyc(4);
		chkv("tx cmd", 16'h0005, 16'(DSP_TX_CMD_O));
		chkv("cmd irqs", 16'(n + 1), 16'(irq_cnt));
		chkv("dsp cmd", 16'h0005, 16'(got_cmd));
		chk1("cmd tone", 1'b1, TX_CMD_TONE_O);
		chk1("guard", 1'b0, TX_GUARD_O);
		CMD_IN_I = 4'h0;
		cyc(4);
		chk1("guard", 1'b1, TX_GUARD_O);
	endtask : t_out

	// A command tone alone must not release the latched alarm.
	task automatic t_rx_alarm();
		int m;
		m = msg_cnt;
		send(4'hA);
		chkv("relays", 16'h000A, 16'(CMD_OUT_O));
		RX_GUARD_I = 1'b0;
		cyc(4);
		chk1("rx alarm", 1'b1, ALARM_LED_O[csa_pkg::ALM_RX]);
		chkv("relays", 16'h0000, 16'(CMD_OUT_O));
		chk1("alarm relay", 1'b1, ALARM_RELAY_O);
		chk1("alarm msg", 1'b1, msg_cnt > m);
		chkv("msg", 16'(1 << csa_pkg::ALM_RX), 16'(ALARM_MSG_O));
		RX_CMD_TONE_I = 1'b1;
		send(4'h3);
		chk1("rx alarm", 1'b1, ALARM_LED_O[csa_pkg::ALM_RX]);
		chkv("relays", 16'h0000, 16'(CMD_OUT_O));
		RX_CMD_TONE_I = 1'b0;
		RX_GUARD_I = 1'b1;
		cyc(4);
		chk1("rx alarm", 1'b0, ALARM_LED_O[csa_pkg::ALM_RX]);
		send(4'h9);
		chkv("relays", 16'h0009, 16'(CMD_OUT_O));
	endtask : t_rx_alarm

	// A slow write is followed at once by a prompt read.
	task automatic t_mem();
		slow = 1'b1;
		mem(1'b1, 12'h003, 16'hBEEF);
		slow = 1'b0;
		mem(1'b0, 12'h003, 16'h0000);
		chkv("mem read", 16'hBEEF, MEM_RDATA_O);
		for (int b = 1; b < 4; b++) begin
			SW_IRQ_I = 3'(1 << (b - 1));
			cyc(1);
			SW_IRQ_I = 3'h0;
			chkv("dsp irq", 16'(1 << b), 16'(DSP_IRQ_O));
		end
	endtask : t_mem

	// A level equal to its limit counts as reached.
	task automatic t_level();
		RX_LEVEL_I = 8'h3F;
		cyc(3);
		chk1("level", 1'b1, ALARM_LED_O[csa_pkg::ALM_LEVEL]);
		RX_LEVEL_I = 8'h40;
		cyc(3);
		chk1("level", 1'b0, ALARM_LED_O[csa_pkg::ALM_LEVEL]);
		TX_LEVEL_I = 8'h3F;
		cyc(3);
		chk1("level", 1'b1, ALARM_LED_O[csa_pkg::ALM_LEVEL]);
		TX_LEVEL_I = 8'h80;
		cyc(3);
		chk1("level", 1'b0, ALARM_LED_O[csa_pkg::ALM_LEVEL]);
	endtask : t_level

	// The guard tone alone is sent, so switching mode still evaluates.
	task automatic t_noise();
		NOISE_LEVEL_I = csa_pkg::NOISE_THRESHOLD;
		cyc(NZ + 6);
		chk1("noise", 1'b0, ALARM_LED_O[csa_pkg::ALM_NOISE]);
		NOISE_LEVEL_I = csa_pkg::NOISE_THRESHOLD + 8'h01;
		cyc(NZ + 6);
		chk1("noise", 1'b1, ALARM_LED_O[csa_pkg::ALM_NOISE]);
		NOISE_LEVEL_I = 8'h10;
	endtask : t_noise

	task automatic t_watchdog();
		alive_en = 1'b0;
		cyc(WD + 6);
		chk1("tx enable", 1'b0, TX_ENABLE_O);
		chk1("wd alarm", 1'b1, ALARM_LED_O[csa_pkg::ALM_WD]);
		send(4'h6);
		chkv("relays", 16'h0000, 16'(CMD_OUT_O));
		// No tone is on the line now, so switching mode must not evaluate.
		NOISE_LEVEL_I = csa_pkg::NOISE_THRESHOLD + 8'h01;
		cyc(NZ + 6);
		chk1("noise", 1'b0, ALARM_LED_O[csa_pkg::ALM_NOISE]);
		SWITCH_MODE_I = 1'b0;
		cyc(NZ + 6);
		chk1("noise", 1'b1, ALARM_LED_O[csa_pkg::ALM_NOISE]);
		SWITCH_MODE_I = 1'b1;
		NOISE_LEVEL_I = 8'h10;
		alive_en = 1'b1;
	endtask : t_watchdog

	// A one-cycle dip must still stretch the module reset.
	task automatic t_supply();
		boot(5'h1F, 1'b1);
		SUPPLY_OK_I = 4'hB;
		cyc(1);
		SUPPLY_OK_I = 4'hF;
		cyc(2);
		chk1("mod reset", 1'b1, MODULE_RESET_O);
		chk1("supply", 1'b1, ALARM_LED_O[csa_pkg::ALM_SUPPLY]);
		send(4'h7);
		chkv("relays", 16'h0000, 16'(CMD_OUT_O));
		cyc(csa_pkg::SUPPLY_RST_CYCLES - 20);
		chk1("mod reset", 1'b1, MODULE_RESET_O);
		cyc(30);
		chk1("mod reset", 1'b0, MODULE_RESET_O);
	endtask : t_supply

	// Each check bit fails alone; the last pass gives no verdict at all.
	task automatic t_fault();
		for (int b = 0; b < 6; b++) begin
			boot(5'h1F ^ 5'(1 << b), b < 5);
			chk1("isolate", 1'b1, IFC_ISOLATE_O);
			chk1("test", 1'b1, ALARM_LED_O[csa_pkg::ALM_TEST]);
			chk1("alarm relay", 1'b1, ALARM_RELAY_O);
		end
	endtask : t_fault

	initial begin
		boot(5'h1F, 1'b1);
		chk1("isolate", 1'b0, IFC_ISOLATE_O);
		chk1("relay supply", 1'b1, RELAY_SUPPLY_EN_O);
		chk1("tx enable", 1'b1, TX_ENABLE_O);
		chk1("guard", 1'b1, TX_GUARD_O);
		t_out();
		t_rx_alarm();
		t_mem();
		t_level();
		t_noise();
		t_watchdog();
		t_supply();
		t_fault();
		wrap_up();
	end
endmodule : csa_top_tb

`default_nettype wire
